// ### common/motor_prot_pkg.sv
// Purpose: Shared constants for the motor drive protection control block
// Assumes: APB with 32-bit data; pclk at 250 MHz
// Notes: Register indices are word indices; byte address is four times the index
package motor_prot_pkg;

  // Register word indices and derived byte addresses
  localparam logic [13:0] EMG_CTRL_IDX = 14'h1fb0;
  localparam logic [13:0] OVL_CTRL_IDX = 14'h1fb1;
  localparam logic [13:0] KEY_IDX = 14'h1fbf;
  localparam logic [13:0] IRQ_STAT_IDX = 14'h1fc0;
  localparam logic [13:0] IRQ_MASK_IDX = 14'h1fc1;
  localparam int ADDR_W = 16;
  localparam logic [15:0] EMG_CTRL_ADDR = {EMG_CTRL_IDX, 2'b00};
  localparam logic [15:0] OVL_CTRL_ADDR = {OVL_CTRL_IDX, 2'b00};
  localparam logic [15:0] KEY_ADDR = {KEY_IDX, 2'b00};
  localparam logic [15:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [15:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

  // Emergency control register fields
  localparam int EMG_SAMPLE_LSB = 4;
  localparam int EMG_STATE_BIT = 2;
  localparam int EMG_RETURN_BIT = 1;
  localparam int EMG_ENABLE_BIT = 0;
  localparam logic [7:0] EMG_CTRL_RESET = 8'h01;

  // Overload control register fields
  localparam int OVL_MANUAL_BIT = 7;
  localparam int OVL_PWM_SYNC_BIT = 6;
  localparam int OVL_TIMER_SYNC_BIT = 5;
  localparam int OVL_STATE_BIT = 4;
  localparam int OVL_CUT_LSB = 2;
  localparam int OVL_HALT_BIT = 1;
  localparam int OVL_ENABLE_BIT = 0;
  localparam logic [7:0] OVL_CTRL_RESET = 8'h00;

  // Disable key sequence
  localparam logic [7:0] KEY_FIRST = 8'h5a;
  localparam logic [7:0] KEY_SECOND = 8'ha5;

  // Interrupt status and mask bits
  localparam int IRQ_EMG_BIT = 0;
  localparam int IRQ_OVL_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Phase cut selector codes
  localparam logic [1:0] CUT_NONE = 2'b00;
  localparam logic [1:0] CUT_ALL = 2'b01;
  localparam logic [1:0] CUT_PWM = 2'b10;
  localparam logic [1:0] CUT_SIDE = 2'b11;

  // Overload sampling period
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_PERIOD_NS = 200;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_e;

endpackage

// ### hw/motor_drive_protection_control.sv
// Purpose: Emergency stop and overload protection control with APB registers
// Assumes: Protective pins are active low and asynchronous; sync pulses are on pclk
// Notes: One wait state on every APB access; pslverr on unmapped addresses
//
// Operation
// - Upper nibble of emergency control sets overload input sample count.
// - Emergency control bit 2 reads one while emergency stop is active.
// - Writing one to emergency control bit 1 releases emergency stop only if the pin is already high; a write while low is ignored.
// - Emergency control bit 0 enables emergency stop; enabled after reset.
// - Clearing the emergency enable needs key 5AH then A5H written first.
// - Overload control bit 5 enables return on the timer 1 sync event.
// - Bits 3:2 select cut phases: none, all, PWM, or upper/lower side.
// - Overload bit 6 enables PWM sync return; manual and sync return act side by side.
// - Overload bit 1 halts the PWM counter while overload is active.
// - Overload bit 0 enables overload protection; disabled raises no interrupt.
`timescale 1ns/100ps
module motor_drive_protection_control
  import motor_prot_pkg::*;
#(
  parameter int PHASES = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protective pins, active low
  input wire logic emg_in_n,
  input wire logic overload_in_n,
  // Sync events from timer 1 and the PWM unit, one-cycle pulses
  input wire logic timer1_sync,
  input wire logic pwm_sync,
  // Phase status from the waveform circuit, upper phases in bits 2:0
  input wire logic [PHASES-1:0] phase_active,
  input wire logic [PHASES-1:0] pwm_phase_map,
  // Power stage control
  output logic outputs_hiz,
  output logic [PHASES-1:0] phase_cut,
  output logic [PHASES-1:0] phase_force_on,
  output logic counter_halt,
  output logic emergency_state_flag,
  output logic overload_state_flag,
  output logic irq
);

  localparam int HALF = PHASES / 2;

  // Synchronised pins
  logic emg_lvl;
  logic ovl_lvl;
  logic emg_lvl_prev_q;

  pin_sync #(
    .WIDTH(2),
    .IDLE(2'b11)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({emg_in_n, overload_in_n}),
    .level_out({emg_lvl, ovl_lvl})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emg_lvl_prev_q <= 1'b1;
    end else begin
      emg_lvl_prev_q <= emg_lvl;
    end
  end

  // APB access decode; writes and reads complete on the edge where pready is seen high
  logic acc_first;
  logic acc_done;
  logic wr_en;
  logic hit_emg;
  logic hit_ovl;
  logic hit_key;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;

  assign acc_first = psel && penable && !pready;
  assign acc_done = psel && penable && pready;
  assign hit_emg = (paddr == EMG_CTRL_ADDR);
  assign hit_ovl = (paddr == OVL_CTRL_ADDR);
  assign hit_key = (paddr == KEY_ADDR);
  assign hit_stat = (paddr == IRQ_STAT_ADDR);
  assign hit_mask = (paddr == IRQ_MASK_ADDR);
  assign hit_any = hit_emg || hit_ovl || hit_key || hit_stat || hit_mask;
  assign wr_en = acc_done && pwrite && hit_any;

  logic wr_emg;
  logic wr_ovl;
  logic wr_key;
  assign wr_emg = wr_en && hit_emg;
  assign wr_ovl = wr_en && hit_ovl;
  assign wr_key = wr_en && hit_key;

  // Control registers
  logic [3:0] sample_time_q;
  logic emg_enable_q;
  logic emg_state_q;
  logic ovl_enable_q;
  logic ovl_halt_en_q;
  logic [1:0] cut_sel_q;
  logic ovl_timer_ret_q;
  logic ovl_pwm_ret_q;
  logic ovl_manual_q;
  logic ovl_state_q;
  logic ovl_return;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  key_state_e key_q;

  // Disable key: a wrong key byte or an emergency control write breaks the sequence, so a stray write cannot unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= KEY_IDLE;
    end else if (wr_key) begin
      unique case (key_q)
        KEY_IDLE: key_q <= (pwdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        KEY_HALF: key_q <= (pwdata[7:0] == KEY_SECOND) ? KEY_OPEN :
                           ((pwdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE);
        KEY_OPEN: key_q <= (pwdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
      endcase
    end else if (wr_emg) begin
      key_q <= KEY_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_time_q <= EMG_CTRL_RESET[EMG_SAMPLE_LSB +: 4];
      emg_enable_q <= EMG_CTRL_RESET[EMG_ENABLE_BIT];
    end else if (wr_emg) begin
      sample_time_q <= pwdata[EMG_SAMPLE_LSB +: 4];
      if (pwdata[EMG_ENABLE_BIT]) begin
        emg_enable_q <= 1'b1;
      end else if (key_q == KEY_OPEN) begin
        emg_enable_q <= 1'b0;
      end
    end
  end

  // Emergency stop: falling edge of the pin while enabled
  logic emg_fall;
  logic emg_event;
  logic emg_return;
  assign emg_fall = emg_lvl_prev_q && !emg_lvl;
  assign emg_event = emg_fall && emg_enable_q;
  // Release is refused while the pin is still low
  assign emg_return = wr_emg && pwdata[EMG_RETURN_BIT] && emg_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emg_state_q <= 1'b0;
    end else if (emg_event) begin
      emg_state_q <= 1'b1;
    end else if (emg_return) begin
      emg_state_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_manual_q <= OVL_CTRL_RESET[OVL_MANUAL_BIT];
      ovl_pwm_ret_q <= OVL_CTRL_RESET[OVL_PWM_SYNC_BIT];
      ovl_timer_ret_q <= OVL_CTRL_RESET[OVL_TIMER_SYNC_BIT];
      cut_sel_q <= OVL_CTRL_RESET[OVL_CUT_LSB +: 2];
      ovl_halt_en_q <= OVL_CTRL_RESET[OVL_HALT_BIT];
      ovl_enable_q <= OVL_CTRL_RESET[OVL_ENABLE_BIT];
    end else begin
      if (wr_ovl) begin
        ovl_pwm_ret_q <= pwdata[OVL_PWM_SYNC_BIT];
        ovl_timer_ret_q <= pwdata[OVL_TIMER_SYNC_BIT];
        cut_sel_q <= pwdata[OVL_CUT_LSB +: 2];
        ovl_halt_en_q <= pwdata[OVL_HALT_BIT];
        ovl_enable_q <= pwdata[OVL_ENABLE_BIT];
      end
      // Manual request stays pending until it takes effect or overload ends
      if (wr_ovl && pwdata[OVL_MANUAL_BIT]) begin
        ovl_manual_q <= 1'b1;
      end else if (ovl_return || !ovl_state_q) begin
        ovl_manual_q <= 1'b0;
      end
    end
  end

  // Overload input sampling
  localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);
  logic [TICK_W-1:0] tick_cnt_q;
  logic sample_tick;
  logic [3:0] low_cnt_q;
  logic [3:0] sample_need;
  logic ovl_detect;
  logic ovl_event;
  logic sync_return;

  assign sample_tick = (tick_cnt_q == TICK_LAST);
  // Counts of zero and one both mean a single sample
  assign sample_need = (sample_time_q == 4'h0) ? 4'h1 : sample_time_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (sample_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 4'h0;
    end else if (ovl_lvl || !ovl_enable_q || ovl_state_q) begin
      low_cnt_q <= 4'h0;
    end else if (sample_tick && !ovl_detect) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  assign ovl_detect = (low_cnt_q >= sample_need);
  assign ovl_event = ovl_detect && ovl_enable_q && !ovl_state_q;

  // Manual or sync return, whichever comes first; sync methods still act while a manual request is pending
  assign sync_return = (ovl_timer_ret_q && timer1_sync) ||
                       (ovl_pwm_ret_q && pwm_sync);
  assign ovl_return = ovl_state_q && ovl_lvl &&
                      (ovl_manual_q || sync_return);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_state_q <= 1'b0;
    end else if (!ovl_enable_q) begin
      ovl_state_q <= 1'b0;
    end else if (ovl_event) begin
      ovl_state_q <= 1'b1;
    end else if (ovl_return) begin
      ovl_state_q <= 1'b0;
    end
  end

  // Side capture for the upper/lower cut mode, frozen at overload entry
  logic [1:0] upper_cnt;
  logic [1:0] lower_cnt;
  logic upper_win_q;

  always_comb begin
    upper_cnt = 2'h0;
    lower_cnt = 2'h0;
    for (int i = 0; i < HALF; i++) begin
      upper_cnt = upper_cnt + {1'b0, phase_active[i]};
      lower_cnt = lower_cnt + {1'b0, phase_active[i + HALF]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_win_q <= 1'b0;
    end else if (ovl_event) begin
      upper_win_q <= (upper_cnt >= 2'h2);
    end
  end

  // Power stage outputs; emergency takes the pins high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cut <= '0;
      phase_force_on <= '0;
    end else if (!ovl_state_q) begin
      phase_cut <= '0;
      phase_force_on <= '0;
    end else begin
      unique case (cut_sel_q)
        CUT_NONE: begin
          phase_cut <= '0;
          phase_force_on <= '0;
        end
        CUT_ALL: begin
          phase_cut <= '1;
          phase_force_on <= '0;
        end
        CUT_PWM: begin
          phase_cut <= pwm_phase_map;
          phase_force_on <= '0;
        end
        CUT_SIDE: begin
          phase_cut <= upper_win_q ? {{HALF{1'b1}}, {HALF{1'b0}}} :
                                     {{HALF{1'b0}}, {HALF{1'b1}}};
          phase_force_on <= upper_win_q ? {{HALF{1'b0}}, {HALF{1'b1}}} :
                                          {{HALF{1'b1}}, {HALF{1'b0}}};
        end
      endcase
    end
  end

  // Motor output selection is held outside; the stage only waits for the release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outputs_hiz <= 1'b0;
      counter_halt <= 1'b0;
      emergency_state_flag <= 1'b0;
      overload_state_flag <= 1'b0;
    end else begin
      outputs_hiz <= emg_state_q || emg_event;
      counter_halt <= ovl_state_q && ovl_halt_en_q;
      emergency_state_flag <= emg_state_q;
      overload_state_flag <= ovl_state_q;
    end
  end

  // Interrupt status: set wins over a write-one clear in the same cycle
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {ovl_event, emg_event};
  assign irq_clr = (wr_en && hit_stat) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_en && hit_mask) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux; return bits are write-only and read as zero except pending manual return
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_emg) begin
      rd_byte[EMG_SAMPLE_LSB +: 4] = sample_time_q;
      rd_byte[EMG_STATE_BIT] = emg_state_q;
      rd_byte[EMG_ENABLE_BIT] = emg_enable_q;
    end else if (hit_ovl) begin
      rd_byte[OVL_MANUAL_BIT] = ovl_manual_q;
      rd_byte[OVL_PWM_SYNC_BIT] = ovl_pwm_ret_q;
      rd_byte[OVL_TIMER_SYNC_BIT] = ovl_timer_ret_q;
      rd_byte[OVL_STATE_BIT] = ovl_state_q;
      rd_byte[OVL_CUT_LSB +: 2] = cut_sel_q;
      rd_byte[OVL_HALT_BIT] = ovl_halt_en_q;
      rd_byte[OVL_ENABLE_BIT] = ovl_enable_q;
    end else if (hit_stat) begin
      rd_byte[1:0] = irq_stat_q;
    end else if (hit_mask) begin
      rd_byte[1:0] = irq_mask_q;
    end
  end

  // One wait state keeps every bus output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first && !hit_any;
      prdata <= (acc_first && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule

// ### hw/pin_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pin inputs
// Assumes: Pins are quasi-static relative to pclk
// Notes: Output changes only once the second and third stages agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin side
  input wire logic [WIDTH-1:0] pin_in,
  // Synchronised level
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: accept a new level only once two stages agree, filtering a one-cycle glitch
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        level_out[i] <= IDLE[i];
      end else if (s2_q[i] == s3_q[i]) begin
        level_out[i] <= s3_q[i];
      end
    end
  end

endmodule

// ### test/motor_drive_protection_control_tb_top.sv
// Purpose: Self-checking bench for the protection control block
// Assumes: APB slave answers after one wait state
// Notes: Overload waits cover the 50-cycle sample tick jitter
`timescale 1ns/100ps
module motor_drive_protection_control_tb_top
  import motor_prot_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic emg_in_n, overload_in_n, timer1_sync, pwm_sync, hiz, halt, emg_st, ovl_st;
  logic emg_fault, ovl_fault;
  logic [1:0] go;
  logic [5:0] act, pmap, cut, fon;
  logic [7:0] cfg;
  logic [5:0] exp_cut [4] = '{6'h00, 6'h3f, 6'h15, 6'h38};
  logic [5:0] exp_fon [4] = '{6'h00, 6'h00, 6'h00, 6'h07};
  int n_errors, checks;

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  motor_drive_protection_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emg_in_n(emg_in_n), .overload_in_n(overload_in_n), .timer1_sync(timer1_sync),
    .pwm_sync(pwm_sync), .phase_active(act), .pwm_phase_map(pmap), .outputs_hiz(hiz),
    .phase_cut(cut), .phase_force_on(fon), .counter_halt(halt),
    .emergency_state_flag(emg_st), .overload_state_flag(ovl_st), .irq(irq));

  power_stage_model stage (
    .emg_fault(emg_fault), .ovl_fault(ovl_fault), .go(go), .outputs_hiz(hiz),
    .emg_in_n(emg_in_n), .overload_in_n(overload_in_n), .timer1_sync(timer1_sync),
    .pwm_sync(pwm_sync), .phase_active(act), .pwm_phase_map(pmap));

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Values read right after the edge are those sampled at it
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask

  task automatic pulse(input logic [1:0] g);
    go <= g;
    tick(1);
    go <= 2'b00;
    tick(5);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    tick(20000);
    n_errors++;
    print_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {emg_fault, ovl_fault, go} = '0;
    tick(8);
    presetn <= 1'b1;
    rd(EMG_CTRL_ADDR, EMG_CTRL_RESET, "emg_rst");
    rd(OVL_CTRL_ADDR, OVL_CTRL_RESET, "ovl_rst");
    rd(KEY_ADDR, 32'h0, "key_rd");
    apb(1'b0, 16'h0010, 32'h0);
    chk("slverr", err, 1'b1);
    // No key, then the key bytes swapped
    wr(EMG_CTRL_ADDR, 32'h0);
    wr(KEY_ADDR, KEY_SECOND);
    wr(KEY_ADDR, KEY_FIRST);
    wr(EMG_CTRL_ADDR, 32'h0);
    rd(EMG_CTRL_ADDR, 8'h01, "emg_locked");
    wr(KEY_ADDR, KEY_FIRST);
    wr(KEY_ADDR, KEY_SECOND);
    wr(EMG_CTRL_ADDR, 32'h0);
    rd(EMG_CTRL_ADDR, 8'h00, "emg_off");
    wr(EMG_CTRL_ADDR, 8'h31);
    wr(IRQ_MASK_ADDR, 2'h2);
    emg_fault <= 1'b1;
    tick(20);
    chk("hiz", hiz, 1'b1);
    chk("emg_flag", emg_st, 1'b1);
    chk("irq_masked", irq, 1'b0);
    rd(IRQ_STAT_ADDR, 2'h1, "stat_emg");
    wr(IRQ_MASK_ADDR, 2'h3);
    tick(3);
    chk("irq_emg", irq, 1'b1);
    wr(EMG_CTRL_ADDR, 8'h33);
    rd(EMG_CTRL_ADDR, 8'h35, "emg_pin_low");
    emg_fault <= 1'b0;
    tick(10);
    wr(EMG_CTRL_ADDR, 8'h33);
    rd(EMG_CTRL_ADDR, 8'h31, "emg_back");
    tick(2);
    chk("emg_flag_off", emg_st, 1'b0);
    wr(IRQ_STAT_ADDR, 2'h1);
    tick(3);
    chk("irq_clr", irq, 1'b0);
    // Two sample ticks at most, below the count of three
    wr(OVL_CTRL_ADDR, 8'h01);
    ovl_fault <= 1'b1;
    tick(60);
    ovl_fault <= 1'b0;
    tick(60);
    chk("ovl_short", ovl_st, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg = {4'h0, m[1:0], 2'b11};
      wr(OVL_CTRL_ADDR, cfg);
      ovl_fault <= 1'b1;
      tick(300);
      rd(OVL_CTRL_ADDR, cfg | 8'h10, "ovl_on");
      chk("cut", cut, exp_cut[m]);
      chk("force", fon, exp_fon[m]);
      chk("halt", halt, 1'b1);
      wr(OVL_CTRL_ADDR, cfg | 8'h80);
      rd(OVL_CTRL_ADDR, cfg | 8'h90, "ovl_pend");
      ovl_fault <= 1'b0;
      tick(10);
      rd(OVL_CTRL_ADDR, cfg, "ovl_manual");
    end
    rd(IRQ_STAT_ADDR, 2'h2, "stat_ovl");
    for (int i = 0; i < 2; i++) begin
      cfg = i ? 8'h27 : 8'h45;
      wr(OVL_CTRL_ADDR, cfg);
      ovl_fault <= 1'b1;
      tick(300);
      chk("halt_cfg", halt, i);
      ovl_fault <= 1'b0;
      tick(10);
      pulse(i ? 2'b01 : 2'b10);
      chk("no_return", ovl_st, 1'b1);
      pulse(i ? 2'b10 : 2'b01);
      chk("sync_return", ovl_st, 1'b0);
    end
    wr(IRQ_STAT_ADDR, 2'h3);
    wr(OVL_CTRL_ADDR, 8'h00);
    ovl_fault <= 1'b1;
    tick(300);
    chk("ovl_off", ovl_st, 1'b0);
    rd(IRQ_STAT_ADDR, 2'h0, "no_ovl_irq");
    chk("irq_off", irq, 1'b0);
    ovl_fault <= 1'b0;
    print_verdict;
  end
endmodule

bind motor_drive_protection_control prot_monitor #(.PHASES(PHASES)) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .emg_in_n(emg_in_n), .overload_in_n(overload_in_n),
  .phase_cut(phase_cut), .counter_halt(counter_halt), .outputs_hiz(outputs_hiz),
  .emergency_state_flag(emergency_state_flag), .overload_state_flag(overload_state_flag));

// ### test/power_stage_model.sv
// Purpose: Power stage and fault sense model
// Assumes: Bench commands faults and sync events after a clock edge
// Notes: Sense lines are the inverted fault commands, so a cleared fault reads high
`timescale 1ns/100ps
module power_stage_model (
  // Bench commands
  input logic emg_fault,
  input logic ovl_fault,
  input logic [1:0] go,
  // Stage control
  input logic outputs_hiz,
  // Pins and events
  output logic emg_in_n,
  output logic overload_in_n,
  output logic timer1_sync,
  output logic pwm_sync,
  output logic [5:0] phase_active,
  output logic [5:0] pwm_phase_map
);
  assign emg_in_n = !emg_fault;
  assign overload_in_n = !ovl_fault;
  assign {timer1_sync, pwm_sync} = go;
  // U and V upper on; nothing conducts while floated
  assign phase_active = outputs_hiz ? 6'h00 : 6'h03;
  assign pwm_phase_map = 6'h15;
endmodule

// ### test/prot_monitor.sv
// Purpose: Port-level assertions for the protection control block
// Assumes: One pclk domain; presetn asynchronous, active low
// Notes: Pin look-backs leave room for the input synchroniser
`timescale 1ns/100ps
module prot_monitor #(
  parameter int PHASES = 6
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Pins and state
  input logic emg_in_n,
  input logic overload_in_n,
  input logic [PHASES-1:0] phase_cut,
  input logic counter_halt,
  input logic outputs_hiz,
  input logic emergency_state_flag,
  input logic overload_state_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  access_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle into access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  emg_hiz_a: assert property ($rose(emergency_state_flag) |-> outputs_hiz)
    else $error("emergency without floated outputs");
  emg_entry_a: assert property ($rose(emergency_state_flag) |-> !$past(emg_in_n, 3))
    else $error("emergency with pin high");
  emg_return_a: assert property ($fell(emergency_state_flag) |-> $past(emg_in_n, 3))
    else $error("emergency return with pin low");
  ovl_entry_a: assert property ($rose(overload_state_flag) |-> !$past(overload_in_n, 3))
    else $error("overload with pin high");
  halt_state_a: assert property (counter_halt |->
    $past(overload_state_flag) or ##[0:1] overload_state_flag)
    else $error("counter halted outside overload");
  cut_state_a: assert property (|phase_cut |->
    $past(overload_state_flag) or ##[0:1] overload_state_flag)
    else $error("phase cut outside overload");

  cover property ($rose(emergency_state_flag));
  cover property ($rose(overload_state_flag));
  cover property (counter_halt);
  cover property (pslverr);
endmodule
